// file: hw/cpu_interrupt_context_unit.sv
// Interrupt logic: flags, enables, vector entry, shadow context, wake
// Assumes one core instruction per mclk cycle and synchronous inputs
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctx_regs.svh"

// Functional notes
// R1 - Any reset clears every enable so no interrupt is taken.
// R2 - Take needs global and own enable; peripheral ones also group enable.
// R3 - Flags set on each event regardless of any enable.
// R4 - Entry flushes prefetch, clears global enable, pushes PC, saves, vectors 0004h.
// R5 - Global enable clear records flags; pending serviced once enabled again.
// R6 - Return pops address, restores context, sets global enable.
// R7 - Handler polls flags and clears them before returning.
// R8 - Synchronous source reaches vector three or four cycles after event.
// R9 - Asynchronous source reaches vector three to five cycles after event.
// R10 - Latency independent of one or two cycle current instruction.
// R11 - External flag sampled for entry at start of every cycle.
// R12 - Only enabled sources wake; vector if global enable else continue.
// R13 - After wake, the next instruction executes before vectoring.
// R14 - External pin is edge triggered, rising or falling by select bit.
// R15 - External flag set every selected edge; vectors with global and pin enable.
// R16 - Entry copies accumulator, status less two bits, bank, pointers, PC latch.
// R17 - Exit restores from shadows; shadow writes take effect instead.
// R18 - Shadow copies readable and writable by software.
module cpu_interrupt_context_unit #(
	parameter int PERIPH_WIDTH = 8
) (
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	// Register port
	input  wire logic [7:0]              regAddr,
	input  wire logic [7:0]              regWrData,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	output logic      [7:0]              regRdData,
	// Event sources
	input  wire logic                    extPin,
	input  wire logic [2:0]              coreEvents,
	input  wire logic [PERIPH_WIDTH-1:0] periphEventsA,
	input  wire logic [PERIPH_WIDTH-1:0] periphEventsB,
	// Core interface
	input  wire logic                    returnFromHandler,
	input  wire logic                    sleeping,
	input  wire logic [14:0]             corePc,
	input  wire logic [7:0]              coreAccum,
	input  wire logic [7:0]              coreStatus,
	input  wire logic [7:0]              coreBank,
	input  wire logic [7:0]              corePtr0Lo,
	input  wire logic [7:0]              corePtr0Hi,
	input  wire logic [7:0]              corePtr1Lo,
	input  wire logic [7:0]              corePtr1Hi,
	input  wire logic [7:0]              corePcHigh,
	output logic                         flushPrefetch,
	output logic                         pushPc,
	output logic      [14:0]             pushAddr,
	output logic                         popPc,
	output logic                         loadVector,
	output logic      [15:0]             vectorAddr,
	output logic                         wakeUp,
	output logic                         restoreCtx,
	output logic      [7:0]              restAccum,
	output logic      [7:0]              restStatus,
	output logic      [7:0]              restBank,
	output logic      [7:0]              restPtr0Lo,
	output logic      [7:0]              restPtr0Hi,
	output logic      [7:0]              restPtr1Lo,
	output logic      [7:0]              restPtr1Hi,
	output logic      [7:0]              restPcHigh,
	output logic                         irqOut
);
	// ---------------------------------------------------------------
	// Enables and flags
	// ---------------------------------------------------------------
	logic                    globalIrqEnable;
	logic                    peripheralGroupEnable;
	logic                    extEdgeSelect;
	logic [3:0]              coreEnables;
	logic [PERIPH_WIDTH-1:0] periphEnableRegA;
	logic [PERIPH_WIDTH-1:0] periphEnableRegB;
	logic [PERIPH_WIDTH-1:0] periphFlagRegA;
	logic [PERIPH_WIDTH-1:0] periphFlagRegB;
	logic [3:0]              coreFlags;
	logic                    extEdge;
	logic                    anyA;
	logic                    anyB;
	logic                    anyCore;
	logic                    pendingEnabled;
	logic [7:0]              shadow [8];
	logic [2:0]              evStatus;
	logic [2:0]              evMask;
	logic [2:0]              evSet;
	logic [1:0]              entryCount;
	irq_ctx_pkg::ctl_state_t state;
	logic                    wasSleeping;

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	wire wrCtl  = regWrite && regAddr == `OFS_CONTROL;
	wire wrEnA  = regWrite && regAddr == `OFS_PERIPH_EN_A;
	wire wrEnB  = regWrite && regAddr == `OFS_PERIPH_EN_B;
	wire wrFlA  = regWrite && regAddr == `OFS_FLAG_A;
	wire wrFlB  = regWrite && regAddr == `OFS_FLAG_B;
	wire wrCore = regWrite && regAddr == `OFS_CORE_FLAG;

	// ---------------------------------------------------------------
	// Take decision
	// ---------------------------------------------------------------
	// First cycle after wake runs the instruction behind the sleep
	wire wakeStep = wasSleeping && !sleeping; // R13
	wire takeIt   = state == irq_ctx_pkg::ST_RUN
		&& globalIrqEnable // R2 R5
		&& pendingEnabled
		&& !sleeping
		&& !wakeStep // R13
		&& !returnFromHandler;

	// ---------------------------------------------------------------
	// Flag groups
	// ---------------------------------------------------------------
	edge_catcher u_edge (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.pinIn     (extPin),
		.risingSel (extEdgeSelect), // R14
		.edgeSeen  (extEdge)
	);

	flag_group #(.WIDTH(4)) u_core_flags (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.events    ({coreEvents, extEdge}), // R3 R15
		.wrEn      (wrCore),
		.wrData    (regWrData[3:0]),
		.enables   (coreEnables),
		.flags     (coreFlags),
		.anyActive (anyCore)
	);

	flag_group #(.WIDTH(PERIPH_WIDTH)) u_flags_a (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.events    (periphEventsA), // R3
		.wrEn      (wrFlA),
		.wrData    (regWrData[PERIPH_WIDTH-1:0]),
		.enables   (periphEnableRegA),
		.flags     (periphFlagRegA),
		.anyActive (anyA)
	);

	flag_group #(.WIDTH(PERIPH_WIDTH)) u_flags_b (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.events    (periphEventsB), // R3
		.wrEn      (wrFlB),
		.wrData    (regWrData[PERIPH_WIDTH-1:0]),
		.enables   (periphEnableRegB),
		.flags     (periphFlagRegB),
		.anyActive (anyB)
	);

	// Flags are level sampled every cycle, so a pending flag fires later too
	assign pendingEnabled = anyCore || (peripheralGroupEnable && (anyA || anyB)); // R2 R5 R11

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			peripheralGroupEnable <= 1'b0; // R1
			extEdgeSelect         <= 1'b1;
			coreEnables           <= '0; // R1
			periphEnableRegA      <= '0; // R1
			periphEnableRegB      <= '0; // R1
		end else if (wrCtl) begin
			peripheralGroupEnable <= regWrData[`CTL_GROUP_EN];
			extEdgeSelect         <= regWrData[`CTL_EDGE_SEL];
			coreEnables           <= regWrData[3:0];
		end else if (wrEnA) begin
			periphEnableRegA <= regWrData[PERIPH_WIDTH-1:0];
		end else if (wrEnB) begin
			periphEnableRegB <= regWrData[PERIPH_WIDTH-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Global enable
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			globalIrqEnable <= 1'b0; // R1
		end else if (takeIt) begin
			globalIrqEnable <= 1'b0; // R4
		end else if (returnFromHandler) begin
			globalIrqEnable <= 1'b1; // R6
		end else if (wrCtl) begin
			globalIrqEnable <= regWrData[`CTL_GLOBAL_EN];
		end
	end

	// ---------------------------------------------------------------
	// Wake tracking
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wasSleeping <= 1'b0;
		end else begin
			wasSleeping <= sleeping; // R13
		end
	end

	// ---------------------------------------------------------------
	// Entry sequence and wake
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= irq_ctx_pkg::ST_RUN;
			entryCount  <= '0;
		end else begin
			case (state)
				irq_ctx_pkg::ST_RUN: begin
					if (sleeping && pendingEnabled) begin
						state <= irq_ctx_pkg::ST_WAKE_STEP; // R12
					end else if (takeIt) begin
						state      <= irq_ctx_pkg::ST_ENTRY;
						entryCount <= 2'(`ENTRY_CYCLES - 1); // R8 R9 R10
					end
				end
				irq_ctx_pkg::ST_WAKE_STEP: begin
					state <= irq_ctx_pkg::ST_RUN; // R13
				end
				irq_ctx_pkg::ST_ENTRY: begin
					if (entryCount == 2'h1) begin
						state <= irq_ctx_pkg::ST_RUN;
					end
					entryCount <= entryCount - 2'h1;
				end
				default: begin
					state <= irq_ctx_pkg::ST_RUN;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Core handshake outputs
	// ---------------------------------------------------------------
	// Entry is fixed length whatever the core was executing
	assign flushPrefetch = takeIt; // R4
	assign pushPc        = takeIt; // R4
	assign popPc         = returnFromHandler; // R6
	assign restoreCtx    = returnFromHandler; // R6 R17
	assign loadVector    = state == irq_ctx_pkg::ST_ENTRY && entryCount == 2'h1; // R4 R8
	assign vectorAddr    = `IRQ_VECTOR; // R4
	assign wakeUp        = state == irq_ctx_pkg::ST_WAKE_STEP; // R12 R13

	// ---------------------------------------------------------------
	// Return address
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pushAddr <= '0;
		end else if (takeIt) begin
			pushAddr <= corePc; // R4
		end
	end

	// ---------------------------------------------------------------
	// Shadow context
	// ---------------------------------------------------------------
	wire [7:0] shIdx = (regAddr - `OFS_SHADOW_BASE) >> 2;
	wire       shHit = regAddr >= `OFS_SHADOW_BASE && regAddr <= `OFS_SHADOW_LAST
		&& regAddr[1:0] == 2'h0;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				shadow[i] <= 8'h00;
			end
		end else if (takeIt) begin
			shadow[0] <= coreAccum; // R16
			shadow[1] <= coreStatus & `STATUS_KEEP_MASK; // R16
			shadow[2] <= coreBank; // R16
			shadow[3] <= corePtr0Lo; // R16
			shadow[4] <= corePtr0Hi; // R16
			shadow[5] <= corePtr1Lo; // R16
			shadow[6] <= corePtr1Hi; // R16
			shadow[7] <= corePcHigh; // R16
		end else if (regWrite && shHit) begin
			shadow[shIdx[2:0]] <= regWrData; // R17 R18
		end
	end

	assign restAccum  = shadow[0]; // R17
	assign restStatus = shadow[1];
	assign restBank   = shadow[2];
	assign restPtr0Lo = shadow[3];
	assign restPtr0Hi = shadow[4];
	assign restPtr1Lo = shadow[5];
	assign restPtr1Hi = shadow[6];
	assign restPcHigh = shadow[7];

	// ---------------------------------------------------------------
	// Event status and interrupt output
	// ---------------------------------------------------------------
	assign evSet = {wakeUp, returnFromHandler, takeIt};

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			evStatus <= '0;
			evMask   <= '0;
		end else begin
			if (regWrite && regAddr == `OFS_STATUS) begin
				evStatus <= (evStatus & ~regWrData[2:0]) | evSet;
			end else begin
				evStatus <= evStatus | evSet;
			end
			if (regWrite && regAddr == `OFS_MASK) begin
				evMask <= regWrData[2:0];
			end
		end
	end

	assign irqOut = |(evStatus & evMask);

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			if (shHit) begin
				regRdData <= shadow[shIdx[2:0]]; // R18
			end else begin
				case (regAddr)
					`OFS_CONTROL: regRdData <= {globalIrqEnable, peripheralGroupEnable,
						extEdgeSelect, 1'b0, coreEnables};
					`OFS_PERIPH_EN_A: regRdData <= 8'(periphEnableRegA);
					`OFS_PERIPH_EN_B: regRdData <= 8'(periphEnableRegB);
					`OFS_FLAG_A:      regRdData <= 8'(periphFlagRegA); // R7
					`OFS_FLAG_B:      regRdData <= 8'(periphFlagRegB); // R7
					`OFS_CORE_FLAG:   regRdData <= {4'h0, coreFlags}; // R7
					`OFS_STATUS:      regRdData <= {5'h00, evStatus};
					`OFS_MASK:        regRdData <= {5'h00, evMask};
					default:          regRdData <= 8'h00;
				endcase
			end
		end else begin
			regRdData <= 8'h00;
		end
	end
endmodule : cpu_interrupt_context_unit
`default_nettype wire

// file: hw/irq_ctx_regs.svh
// Register offsets, field positions and timing counts
// Assumes inclusion by bare name from hw/ design files
`ifndef IRQ_CTX_REGS_SVH
`define IRQ_CTX_REGS_SVH

// Register offsets (byte addresses, one word each)
`define OFS_CONTROL     8'h00
`define OFS_PERIPH_EN_A 8'h04
`define OFS_PERIPH_EN_B 8'h08
`define OFS_FLAG_A      8'h0c
`define OFS_FLAG_B      8'h10
`define OFS_CORE_FLAG   8'h14
`define OFS_STATUS      8'h18
`define OFS_MASK        8'h1c
`define OFS_SHADOW_BASE 8'h40
`define OFS_SHADOW_LAST 8'h5c

// Control register fields
`define CTL_GLOBAL_EN   7
`define CTL_GROUP_EN    6
`define CTL_CORE_EN_LSB 0
`define CTL_EDGE_SEL    5

// Core flag fields
`define CORE_EXT_PIN    0

// Status bits of the interrupt output block
`define EV_ENTRY        0
`define EV_RETURN       1
`define EV_WAKE         2

// Vector and latency
`define IRQ_VECTOR      16'h0004
`define ENTRY_CYCLES    3

// Status register: watchdog expiry and sleep entered bits are not saved
`define STATUS_KEEP_MASK 8'he7

`endif

// file: hw/irq_ctx_pkg.sv
// Types shared by the interrupt context unit files
// Assumes nothing of its surroundings
package irq_ctx_pkg;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_ENTRY,
		ST_WAKE_STEP
	} ctl_state_t;
	typedef logic [7:0] byte_t;
endpackage : irq_ctx_pkg

// file: hw/edge_catcher.sv
// Edge detector for the external interrupt pin
// Assumes pin already synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module edge_catcher (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic pinIn,
	input  wire logic risingSel,
	output logic      edgeSeen
);
	logic pinLast;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pinLast <= 1'b0;
		end else begin
			pinLast <= pinIn;
		end
	end

	assign edgeSeen = risingSel ? (pinIn & ~pinLast) : (~pinIn & pinLast); // R14
endmodule : edge_catcher
`default_nettype wire

// file: hw/flag_group.sv
// Group of sticky interrupt flags with enables
// Assumes event pulses synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module flag_group #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] events,
	input  wire logic             wrEn,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [WIDTH-1:0] enables,
	output logic      [WIDTH-1:0] flags,
	output logic                  anyActive
);
	// Set wins over a software write of zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flags <= '0;
		end else if (wrEn) begin
			flags <= wrData | events; // R3
		end else begin
			flags <= flags | events; // R3
		end
	end

	assign anyActive = |(flags & enables);
endmodule : flag_group
`default_nettype wire

// file: tb/core_model.sv
// Behavioural core: context source, restore on return, sleep handshake
// Assumes the unit's outputs are synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        goSleep,
	input  wire logic        wakeUp,
	input  wire logic        restoreCtx,
	input  wire logic [63:0] restCtx,
	output logic      [63:0] ctx,
	output logic             sleeping
);
	// Context keeps moving so a stale capture shows
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			ctx <= 64'h0;
		else if (restoreCtx)
			ctx <= restCtx;
		else
			ctx <= ctx + 64'h1b3d_5f71_9a2c_4e87;
	end
	// Sleep ends at the clock edge that samples wakeUp; goSleep wins over wakeUp
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			sleeping <= 1'b0;
		else if (goSleep)
			sleeping <= 1'b1;
		else if (wakeUp)
			sleeping <= 1'b0;
	end
endmodule : core_model
`default_nettype wire

// file: tb/cpu_interrupt_context_unit_assertions.sv
// Port checker for the interrupt context unit
// Assumes one clock domain, bound to the top module by name
`timescale 1ns/100ps
`default_nettype none
module irq_ctx_checker (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        returnFromHandler,
	input wire logic        sleeping,
	input wire logic [14:0] corePc,
	input wire logic [7:0]  coreAccum,
	input wire logic [7:0]  coreStatus,
	input wire logic        flushPrefetch,
	input wire logic        pushPc,
	input wire logic [14:0] pushAddr,
	input wire logic        popPc,
	input wire logic        loadVector,
	input wire logic [15:0] vectorAddr,
	input wire logic        wakeUp,
	input wire logic        restoreCtx,
	input wire logic [7:0]  restAccum,
	input wire logic [7:0]  restStatus
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	vec_fixed_a: assert property (vectorAddr == 16'h0004) else $error("vector moved");
	take_pair_a: assert property (pushPc == flushPrefetch) else $error("flush split");
	take_vec_a: assert property (pushPc |-> ##2 loadVector) else $error("late vector");
	vec_cause_a: assert property (loadVector |-> $past(pushPc, 2)) else $error("stray vector");
	one_take_a: assert property (pushPc |=> !pushPc) else $error("global kept");
	push_pc_a: assert property (pushPc |=> pushAddr == $past(corePc)) else $error("bad push");
	save_ctx_a: assert property (pushPc |=> restAccum == $past(coreAccum)
		&& restStatus == ($past(coreStatus) & 8'he7)) else $error("bad save");
	ret_pop_a: assert property (returnFromHandler |-> popPc && restoreCtx) else $error("no pop");
	sleep_hold_a: assert property (sleeping |-> !pushPc) else $error("take asleep");
	wake_src_a: assert property (wakeUp |-> $past(sleeping)) else $error("stray wake");
	wake_step_a: assert property (wakeUp |=> !pushPc) else $error("take in wake step");
endmodule : irq_ctx_checker
bind cpu_interrupt_context_unit irq_ctx_checker i_irq_ctx_checker (
	.mclk, .reset_n, .returnFromHandler, .sleeping, .corePc, .coreAccum, .coreStatus,
	.flushPrefetch, .pushPc, .pushAddr, .popPc, .loadVector, .vectorAddr, .wakeUp,
	.restoreCtx, .restAccum, .restStatus);
`default_nettype wire

// file: tb/cpu_interrupt_context_unit_tb_top.sv
// Self-checking bench for the interrupt context unit
// Assumes hw/ on the include path and core_model as far side
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctx_regs.svh"
module cpu_interrupt_context_unit_tb_top;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [7:0]  regWrData = 8'h00;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        extPin = 1'b0;
	logic [2:0]  coreEvents = 3'h0;
	logic [7:0]  periphEventsA = 8'h00;
	logic [7:0]  periphEventsB = 8'h00;
	logic        returnFromHandler = 1'b0;
	logic        goSleep = 1'b0;
	logic [7:0]  regRdData, coreAccum, coreStatus, coreBank, corePcHigh;
	logic [7:0]  corePtr0Lo, corePtr0Hi, corePtr1Lo, corePtr1Hi;
	logic [7:0]  restAccum, restStatus, restBank, restPcHigh;
	logic [7:0]  restPtr0Lo, restPtr0Hi, restPtr1Lo, restPtr1Hi;
	logic [14:0] corePc, pushAddr;
	logic [15:0] vectorAddr;
	logic [63:0] ctx;
	logic        sleeping, flushPrefetch, pushPc, popPc, loadVector, wakeUp, restoreCtx, irqOut;
	logic [31:0] v;
	logic [15:0] e;
	logic [15:0] expQ[$];
	int          failures = 0;
	int          comparisons = 0;
	int          takes = 0;
	int          seed = 39;
	assign {coreAccum, coreStatus, coreBank, corePtr0Lo, corePtr0Hi, corePtr1Lo, corePtr1Hi,
		corePcHigh} = ctx;
	assign corePc = ctx[46:32];
	cpu_interrupt_context_unit i_cpu_interrupt_context_unit (
		.mclk, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .extPin,
		.coreEvents, .periphEventsA, .periphEventsB, .returnFromHandler, .sleeping, .corePc,
		.coreAccum, .coreStatus, .coreBank, .corePtr0Lo, .corePtr0Hi, .corePtr1Lo,
		.corePtr1Hi, .corePcHigh, .flushPrefetch, .pushPc, .pushAddr, .popPc, .loadVector,
		.vectorAddr, .wakeUp, .restoreCtx, .restAccum, .restStatus, .restBank, .restPtr0Lo,
		.restPtr0Hi, .restPtr1Lo, .restPtr1Hi, .restPcHigh, .irqOut);
	core_model i_core_model (.mclk, .reset_n, .goSleep, .wakeUp, .restoreCtx, .ctx, .sleeping,
		.restCtx({restAccum, restStatus, restBank, restPtr0Lo, restPtr0Hi, restPtr1Lo,
		restPtr1Hi, restPcHigh}));
	always #5 mclk = ~mclk;
	// Reference model: takes and captured context
	always @(negedge mclk) begin
		if (loadVector === 1'b1)
			takes++;
		if (pushPc === 1'b1)
			expQ.push_back({coreAccum, coreStatus & 8'he7});
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		@(negedge mclk);
		chk(regRdData, x);
	endtask : rd
	task automatic evA(input logic [7:0] x);
		@(posedge mclk);
		periphEventsA <= x;
		@(posedge mclk);
		periphEventsA <= 8'h00;
	endtask : evA
	task automatic ret;
		@(posedge mclk);
		returnFromHandler <= 1'b1;
		@(posedge mclk);
		returnFromHandler <= 1'b0;
	endtask : ret
	task automatic pin(input logic x);
		@(posedge mclk);
		extPin <= x;
	endtask : pin
	// Cycles until the vector is loaded
	task automatic lat(input int x);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (loadVector !== 1'b1 && n < 12);
		chk(16'(n), 16'(x));
	endtask : lat
	task automatic close_out;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	initial begin
		#100000;
		failures++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		rd(`OFS_CONTROL, 8'h20);
		for (int i = 1; i < 8; i++)
			rd(8'(i * 4), 8'h00);
		rd(8'h30, 8'h00);
		$display("test reset done");
		v = $random(seed);
		@(posedge mclk);
		periphEventsA <= v[7:0];
		periphEventsB <= v[15:8];
		coreEvents <= v[18:16];
		@(posedge mclk);
		periphEventsA <= 8'h00;
		periphEventsB <= 8'h00;
		coreEvents <= 3'h0;
		rd(`OFS_FLAG_A, v[7:0]);
		rd(`OFS_FLAG_B, v[15:8]);
		rd(`OFS_CORE_FLAG, {4'h0, v[18:16], 1'b0});
		wr(`OFS_FLAG_A, 8'h00);
		wr(`OFS_FLAG_B, 8'h00);
		wr(`OFS_CORE_FLAG, 8'h00);
		chk(16'(takes), 16'h0);
		$display("test flags done");
		wr(`OFS_PERIPH_EN_A, 8'h01);
		wr(`OFS_CONTROL, 8'ha0);
		evA(8'h01);
		repeat (6) @(posedge mclk);
		chk(16'(takes), 16'h0);
		wr(`OFS_CONTROL, 8'he0);
		lat(`ENTRY_CYCLES);
		repeat (2) @(posedge mclk);
		e = expQ.pop_front();
		rd(`OFS_SHADOW_BASE, e[15:8]);
		rd(8'h44, e[7:0]);
		rd(`OFS_CONTROL, 8'h60);
		evA(8'h01);
		wr(`OFS_SHADOW_BASE, 8'h5a);
		@(negedge mclk);
		chk(restAccum, 8'h5a);
		wr(8'h5c, 8'h3c);
		rd(8'h5c, 8'h3c);
		ret();
		lat(`ENTRY_CYCLES);
		e = expQ.pop_front();
		chk(16'(e[15:8]), 16'h005a);
		wr(`OFS_FLAG_A, 8'h00);
		ret();
		repeat (6) @(posedge mclk);
		chk(16'(takes), 16'h2);
		rd(`OFS_CONTROL, 8'he0);
		$display("test entry done");
		wr(`OFS_CONTROL, 8'ha1);
		pin(1'b1);
		lat(`ENTRY_CYCLES + 1);
		wr(`OFS_CORE_FLAG, 8'h00);
		ret();
		pin(1'b0);
		rd(`OFS_CORE_FLAG, 8'h00);
		wr(`OFS_CONTROL, 8'h01);
		pin(1'b1);
		rd(`OFS_CORE_FLAG, 8'h00);
		pin(1'b0);
		rd(`OFS_CORE_FLAG, 8'h01);
		chk(16'(takes), 16'h3);
		$display("test pin done");
		wr(`OFS_CORE_FLAG, 8'h00);
		for (int g = 0; g < 2; g++) begin
			wr(`OFS_CONTROL, g ? 8'h81 : 8'h01);
			@(posedge mclk);
			goSleep <= 1'b1;
			extPin <= 1'b1;
			@(posedge mclk);
			goSleep <= 1'b0;
			evA(8'h02);
			repeat (4) @(posedge mclk);
			chk(sleeping, 1'b1);
			pin(1'b0);
			repeat (8) @(posedge mclk);
			chk(sleeping, 1'b0);
			chk(16'(takes), 16'(3 + g));
			wr(`OFS_CORE_FLAG, 8'h00);
		end
		$display("test sleep done");
		@(negedge mclk);
		chk(irqOut, 1'b0);
		wr(`OFS_MASK, 8'h04);
		@(negedge mclk);
		chk(irqOut, 1'b1);
		wr(`OFS_STATUS, 8'h04);
		@(negedge mclk);
		chk(irqOut, 1'b0);
		rd(`OFS_STATUS, 8'h03);
		$display("test irq done");
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rd(`OFS_CONTROL, 8'h20);
		rd(`OFS_PERIPH_EN_A, 8'h00);
		$display("test rereset done");
		close_out();
	end
endmodule : cpu_interrupt_context_unit_tb_top
`default_nettype wire
